//--- wps_pkg.sv
// Purpose: Shared constants for the waveform pin select block.
// Assumes: Classic Wishbone register access with 32-bit data.
// Notes:   Offsets are byte addresses of aligned words.
package wps_pkg;
    localparam int unsigned NCH        = 8;
    localparam int unsigned AW         = 6;
    localparam int unsigned TW         = 16;
    // ==========================================================
    // Register offsets
    localparam logic [5:0] OFS_ENABLE  = 6'h00;
    localparam logic [5:0] OFS_FSEL    = 6'h04;
    localparam logic [5:0] OFS_PDIR    = 6'h08;
    localparam logic [5:0] OFS_PDATA   = 6'h0C;
    localparam logic [5:0] OFS_TCTRL   = 6'h10;
    localparam logic [5:0] OFS_PERIOD  = 6'h14;
    localparam logic [5:0] OFS_STATUS  = 6'h18;
    localparam logic [5:0] OFS_CLEAR   = 6'h1C;
    localparam logic [5:0] OFS_IRQEN   = 6'h20;
    localparam logic [5:0] OFS_PINS    = 6'h24;
    localparam logic [5:0] OFS_TIMER   = 6'h28;
    localparam logic [5:0] OFS_WAVE    = 6'h2C;
    localparam logic [5:0] OFS_CMP     = 6'h30;
    // ==========================================================
    // Field positions
    localparam int unsigned TC_RST_CH0 = 0;
    localparam int unsigned TC_RST_ALT = 1;
    localparam int unsigned TC_RST_PER = 2;
    localparam int unsigned WC_LO      = 0;
    localparam int unsigned WC_HI      = 1;
    localparam int unsigned WC_DEF     = 2;
    localparam int unsigned WC_INV     = 3;
    localparam int unsigned WC_W       = 4;
    // Output type codes from the two mode bits.
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_SR     = 2'h1;
    localparam logic [1:0] MODE_PHASE  = 2'h2;
    // Reset-select codes that clear the timer; every other code lets it run freely.
    localparam logic [2:0] TC_SEL_CH0  = 3'h1;
    localparam logic [2:0] TC_SEL_PER  = 3'h4;
    localparam logic [TW-1:0] CMP_RESET  = 16'hFFFF;
    localparam logic [TW-1:0] TIMER_ZERO = 16'h0000;
    localparam logic [TW-1:0] TIMER_ONE  = 16'h0001;
endpackage : wps_pkg

//--- wps_route_if.sv
// Purpose: Carries per-channel routing selection between core and router.
// Assumes: All signals on clk_i of the top.
// Notes:   None.
`timescale 1ns/1ps
interface wps_route_if;
    logic [7:0] enable;
    logic [7:0] fsel;
    logic [7:0] mode_lo;
    logic [7:0] mode_hi;
    logic [7:0] pdir;
    logic [7:0] pdata;
    logic [7:0] wave;
    logic [7:0] pin_oe;
    logic [7:0] pin_o;
    logic [7:0] sr_pair;
    modport core (output enable, fsel, mode_lo, mode_hi, pdir, pdata, wave,
                  input pin_oe, pin_o, sr_pair);
    modport route (input enable, fsel, mode_lo, mode_hi, pdir, pdata, wave,
                   output pin_oe, pin_o, sr_pair);
endinterface : wps_route_if

//--- wps_route.sv
// Purpose: Combinational pin routing for eight capture/compare pins.
// Assumes: Control bits come from registers on the same clock.
// Notes:   No state; changes show on the next clock after a write.
`timescale 1ns/1ps
module wps_route (
    // Routing carrier
    wps_route_if.route r
);
    // ==========================================================
    // Per-channel pin selection
    for (genvar c = 0; c < 8; c++) begin : g_ch
        logic [1:0] mode;
        logic       wave_sel;
        assign mode = {r.mode_hi[c], r.mode_lo[c]};
        // The odd member of a pair keeps port behaviour; the even pin carries the wave.
        if (c % 2 == 0) begin : g_even
            assign wave_sel = r.enable[c] && !r.fsel[c] &&
                              (mode == wps_pkg::MODE_SINGLE ||
                               mode == wps_pkg::MODE_SR ||
                               mode == wps_pkg::MODE_PHASE);
            assign r.sr_pair[c] = r.enable[c] && !r.fsel[c] && mode == wps_pkg::MODE_SR;
        end else begin : g_odd
            // An odd channel joins a pair by its own mode or by its even partner's.
            assign r.sr_pair[c] = r.enable[c] && !r.fsel[c] &&
                                  (mode == wps_pkg::MODE_SR || r.sr_pair[c - 1]);
            assign wave_sel = r.enable[c] && !r.fsel[c] && !r.sr_pair[c] &&
                              (mode == wps_pkg::MODE_SINGLE ||
                               mode == wps_pkg::MODE_PHASE);
        end
        assign r.pin_oe[c] = wave_sel ? 1'b1 : r.pdir[c];
        assign r.pin_o[c]  = wave_sel ? r.wave[c] : r.pdata[c];
    end
endmodule : wps_route

//--- wps_top.sv
// Purpose: Pin select and set/reset pairing for an eight-channel compare unit.
// Assumes: One 200 MHz clock; pins are sampled through two flip-flops.
// Notes:   Single-phase and phase-delayed waves come in on wave_ext_i.
// ==========================================================
// Summary of operation
// - Channel 0 compare as timer reset disables the channel 0/1 pair.
// - A set/reset pair uses even and odd channel; wave shows on even pin.
// - The odd pin of a pair is a general port from port registers.
// - Enable and function-select bits jointly set each pin's direction.
// - Enable 0 makes the pin a plain port with port direction.
// - Enabled with select 1: port direction, capture sees the pin.
// - Enabled with select 0: mode 00 single, 01 set/reset, 10 phase-delayed.
// - All reset-select bits 0 lets the timer run freely.
// - Timer resets on channel 0 match only with select code 1, on period match only with code 4.
// - Even match drives pin high, odd match drives it low.
// - Even and odd matches set their own channel flags.
// - Pair output runs while both enables are 1, stops when either is 0.
`timescale 1ns/1ps
module wps_top (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Timer count enable and external wave sources
    input  wire logic        tick_i,
    input  wire logic [7:0]  wave_ext_i,
    // Pins
    input  wire logic [7:0]  pin_i,
    output logic      [7:0]  pin_o,
    output logic      [7:0]  pin_oe_o,
    output logic      [7:0]  capture_o,
    // Interrupt
    output logic             irq_o
);
    localparam int unsigned TW = wps_pkg::TW;

    wps_route_if rif ();
    wps_route u_route (.r(rif));

    // ==========================================================
    // Register state
    logic [7:0]    channel_enable_reg;
    logic [7:0]    function_select_reg;
    logic [7:0]    port_dir_bits;
    logic [7:0]    port_data;
    logic [2:0]    timer_ctrl;
    logic [TW-1:0] timer_period_reg;
    logic [7:0]    match_flag_reg;
    logic [7:0]    irq_enable;
    logic [3:0]    wave_ctrl_reg [8];
    logic [TW-1:0] cmp_value [8];
    logic [TW-1:0] timer;
    logic [7:0]    sr_level;
    logic [7:0]    pin_s1;
    logic [7:0]    pin_s2;
    logic          ack;

    logic [7:0]    next_channel_enable_reg;
    logic [7:0]    next_function_select_reg;
    logic [7:0]    next_port_dir_bits;
    logic [7:0]    next_port_data;
    logic [2:0]    next_timer_ctrl;
    logic [TW-1:0] next_timer_period_reg;
    logic [7:0]    next_match_flag_reg;
    logic [7:0]    next_irq_enable;
    logic [3:0]    next_wave_ctrl_reg [8];
    logic [TW-1:0] next_cmp_value [8];
    logic [TW-1:0] next_timer;
    logic [7:0]    next_sr_level;
    logic          next_ack;
    logic [31:0]   next_dat;

    logic          bus_req;
    logic          wr;
    logic [7:0]    match;
    logic [7:0]    clr;
    logic          reset_ch0;
    logic          reset_per;
    logic          tmr_clear;
    logic [7:0]    wave;
    logic [6:0]    cmp_ofs [8];

    // ==========================================================
    // Compare matches and timer reset source
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            match[i] = tick_i && (timer == cmp_value[i]);
        end
        reset_ch0 = (timer_ctrl == wps_pkg::TC_SEL_CH0) && match[0];
        reset_per = (timer_ctrl == wps_pkg::TC_SEL_PER) && tick_i && (timer == timer_period_reg);
        tmr_clear = reset_ch0 || reset_per;
        next_timer = timer;
        if (tmr_clear) begin
            next_timer = wps_pkg::TIMER_ZERO;
        end else if (tick_i) begin
            next_timer = TW'(timer + wps_pkg::TIMER_ONE);
        end
    end

    // ==========================================================
    // Set/reset levels per even channel
    for (genvar p = 0; p < 8; p += 2) begin : g_sr
        logic run;
        logic blocked;
        logic level;
        logic [3:0] wc;
        assign wc      = wave_ctrl_reg[p];
        assign blocked = (p == 0) && timer_ctrl[wps_pkg::TC_RST_CH0];
        assign run     = rif.sr_pair[p] && channel_enable_reg[p + 1] && !blocked;
        // The odd bit of a pair records a match since the start, so until then
        // the pin follows the default level even when software rewrites it.
        always_comb begin
            next_sr_level[p]     = sr_level[p];
            next_sr_level[p + 1] = sr_level[p + 1];
            if (!run) begin
                next_sr_level[p]     = wc[wps_pkg::WC_DEF];
                next_sr_level[p + 1] = 1'b0;
            end else if (match[p + 1]) begin
                next_sr_level[p]     = 1'b0;
                next_sr_level[p + 1] = 1'b1;
            end else if (match[p]) begin
                next_sr_level[p]     = 1'b1;
                next_sr_level[p + 1] = 1'b1;
            end
        end
        assign level   = sr_level[p + 1] ? sr_level[p] : wc[wps_pkg::WC_DEF];
        assign wave[p] = run ? (level ^ wc[wps_pkg::WC_INV]) : wave_ext_i[p];
        assign wave[p + 1] = wave_ext_i[p + 1];
    end

    // ==========================================================
    // Wishbone access, flags and control registers
    assign bus_req = cyc_i && stb_i && !ack;
    assign wr      = bus_req && we_i && sel_i[0];
    always_comb begin
        // Compares 4 to 7 lie beyond the six-bit window and keep their reset value.
        for (int i = 0; i < 8; i++) begin
            cmp_ofs[i] = 7'(wps_pkg::OFS_CMP) + 7'(4 * i);
        end
        next_channel_enable_reg  = channel_enable_reg;
        next_function_select_reg = function_select_reg;
        next_port_dir_bits       = port_dir_bits;
        next_port_data           = port_data;
        next_timer_ctrl          = timer_ctrl;
        next_timer_period_reg    = timer_period_reg;
        next_irq_enable          = irq_enable;
        next_wave_ctrl_reg       = wave_ctrl_reg;
        next_cmp_value           = cmp_value;
        clr                      = 8'h00;
        next_ack                 = bus_req;
        next_dat                 = 32'h0000_0000;
        if (wr) begin
            unique case (adr_i)
                wps_pkg::OFS_ENABLE: next_channel_enable_reg  = dat_i[7:0];
                wps_pkg::OFS_FSEL:   next_function_select_reg = dat_i[7:0];
                wps_pkg::OFS_PDIR:   next_port_dir_bits       = dat_i[7:0];
                wps_pkg::OFS_PDATA:  next_port_data           = dat_i[7:0];
                wps_pkg::OFS_TCTRL:  next_timer_ctrl          = dat_i[2:0];
                wps_pkg::OFS_CLEAR:  clr                      = dat_i[7:0];
                wps_pkg::OFS_IRQEN:  next_irq_enable          = dat_i[7:0];
                default: begin
                end
            endcase
            if (adr_i == wps_pkg::OFS_PERIOD && sel_i[1]) begin
                next_timer_period_reg = dat_i[TW-1:0];
            end
            for (int i = 0; i < 8; i++) begin
                if (7'(adr_i) == cmp_ofs[i] && sel_i[1]) begin
                    next_cmp_value[i] = dat_i[TW-1:0];
                end
                if (adr_i == 6'(wps_pkg::OFS_WAVE) && i == 0) begin
                    next_wave_ctrl_reg[0] = dat_i[3:0];
                end
            end
        end
        if (bus_req && !we_i) begin
            unique case (adr_i)
                wps_pkg::OFS_ENABLE: next_dat[7:0]    = channel_enable_reg;
                wps_pkg::OFS_FSEL:   next_dat[7:0]    = function_select_reg;
                wps_pkg::OFS_PDIR:   next_dat[7:0]    = port_dir_bits;
                wps_pkg::OFS_PDATA:  next_dat[7:0]    = port_data;
                wps_pkg::OFS_TCTRL:  next_dat[2:0]    = timer_ctrl;
                wps_pkg::OFS_PERIOD: next_dat[TW-1:0] = timer_period_reg;
                wps_pkg::OFS_STATUS: next_dat[7:0]    = match_flag_reg;
                wps_pkg::OFS_IRQEN:  next_dat[7:0]    = irq_enable;
                wps_pkg::OFS_PINS:   next_dat[7:0]    = pin_s2;
                wps_pkg::OFS_TIMER:  next_dat[TW-1:0] = timer;
                default: begin
                    for (int i = 0; i < 8; i++) begin
                        if (7'(adr_i) == cmp_ofs[i]) begin
                            next_dat[TW-1:0] = cmp_value[i];
                        end
                    end
                end
            endcase
        end
        // A match in the clearing cycle keeps its flag set.
        next_match_flag_reg = (match_flag_reg & ~clr) | match;
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_enable_reg  <= 8'h00;
            function_select_reg <= 8'h00;
            port_dir_bits       <= 8'h00;
            port_data           <= 8'h00;
            timer_ctrl          <= 3'h0;
            timer_period_reg    <= wps_pkg::CMP_RESET;
            match_flag_reg      <= 8'h00;
            irq_enable          <= 8'h00;
            timer               <= wps_pkg::TIMER_ZERO;
            sr_level            <= 8'h00;
            ack                 <= 1'b0;
            dat_o               <= 32'h0000_0000;
            pin_s1              <= 8'h00;
            pin_s2              <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                wave_ctrl_reg[i] <= 4'h0;
                cmp_value[i]     <= wps_pkg::CMP_RESET;
            end
        end else begin
            channel_enable_reg  <= next_channel_enable_reg;
            function_select_reg <= next_function_select_reg;
            port_dir_bits       <= next_port_dir_bits;
            port_data           <= next_port_data;
            timer_ctrl          <= next_timer_ctrl;
            timer_period_reg    <= next_timer_period_reg;
            match_flag_reg      <= next_match_flag_reg;
            irq_enable          <= next_irq_enable;
            timer               <= next_timer;
            sr_level            <= next_sr_level;
            ack                 <= next_ack;
            dat_o               <= next_dat;
            pin_s1              <= pin_i;
            pin_s2              <= pin_s1;
            wave_ctrl_reg       <= next_wave_ctrl_reg;
            cmp_value           <= next_cmp_value;
        end
    end

    // ==========================================================
    // Routing carrier and outputs
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            rif.mode_lo[i] = wave_ctrl_reg[i][wps_pkg::WC_LO];
            rif.mode_hi[i] = wave_ctrl_reg[i][wps_pkg::WC_HI];
        end
    end
    assign rif.enable = channel_enable_reg;
    assign rif.fsel   = function_select_reg;
    assign rif.pdir   = port_dir_bits;
    assign rif.pdata  = port_data;
    assign rif.wave   = wave;
    assign pin_o      = rif.pin_o;
    assign pin_oe_o   = rif.pin_oe;
    assign capture_o  = pin_s2 & channel_enable_reg & function_select_reg;
    assign ack_o      = ack;
    assign irq_o      = |(match_flag_reg & irq_enable);

    // ==========================================================
    // Checks
    sequence even_hit_s(int c);
        tick_i && timer == cmp_value[c] && timer != cmp_value[c + 1];
    endsequence
    pair_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (g_sr[0].run and even_hit_s(0)) |=> sr_level[0])
        else $error("Even match did not raise the pair level.");
    pair_fall_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (g_sr[0].run && match[1]) |=> !sr_level[0])
        else $error("Odd match did not lower the pair level.");
    pair_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
        timer_ctrl[wps_pkg::TC_RST_CH0] |-> !g_sr[0].run)
        else $error("Channel 0/1 pair ran with channel 0 reset source.");
    odd_port_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rif.sr_pair[1] |-> pin_oe_o[1] == port_dir_bits[1] && pin_o[1] == port_data[1])
        else $error("Odd pin of a pair left port control.");
    port_plain_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !channel_enable_reg[5] |-> pin_oe_o[5] == port_dir_bits[5])
        else $error("Disabled pin not under port direction.");
    free_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (timer_ctrl == 3'h0 && tick_i) |=> timer == TW'($past(timer) + 16'h0001))
        else $error("Free-running timer did not advance.");
    flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
        match[0] |=> match_flag_reg[0])
        else $error("Match flag not set.");
    idle_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (g_sr[0].run && !sr_level[1]) |->
            pin_o[0] == (wave_ctrl_reg[0][wps_pkg::WC_DEF] ^ wave_ctrl_reg[0][wps_pkg::WC_INV]))
        else $error("Idle pair level differs from default.");
endmodule : wps_top

//--- waveform_pin_select_tb_top.sv
// Purpose: Self-checking bench for the waveform pin select block.
// Assumes: Register map and one-cycle ack as handed over by the designer.
// Notes:   Timer bounds allow a few cycles of match and bus read latency.
`timescale 1ns/1ps
module waveform_pin_select_tb_top;
    // ==========================================================
    // Signals
    logic        clk_i      = 1'b0;
    logic        rst_i      = 1'b1;
    logic        cyc_i      = 1'b0;
    logic        stb_i      = 1'b0;
    logic        we_i       = 1'b0;
    logic [5:0]  adr_i      = 6'h00;
    logic [3:0]  sel_i      = 4'hF;
    logic [31:0] dat_i      = 32'h0000_0000;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        tick_i     = 1'b0;
    logic [7:0]  wave_ext_i = 8'h5A;
    logic [7:0]  pin_i      = 8'h00;
    logic [7:0]  pin_o;
    logic [7:0]  pin_oe_o;
    logic [7:0]  capture_o;
    logic        irq_o;
    int          errors     = 0;
    int          num_checks = 0;
    logic [31:0] q;
    logic [31:0] mx;

    always #2.5 clk_i = ~clk_i;

    wps_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
                 .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
                 .tick_i(tick_i), .wave_ext_i(wave_ext_i), .pin_i(pin_i), .pin_o(pin_o),
                 .pin_oe_o(pin_oe_o), .capture_o(capture_o), .irq_o(irq_o));

    // ==========================================================
    // Tasks
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_in(input string nm, input logic [31:0] lo, input logic [31:0] hi,
                          input logic [31:0] g);
        num_checks++;
        if (((g >= lo) && (g <= hi)) !== 1'b1) begin
            errors++;
            $display("MISMATCH %s expected %h to %h seen %h", nm, lo, hi, g);
        end
    endtask : chk_in

    // Holds the request until ack is sampled high, then leaves one idle cycle.
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            $display("MISMATCH ack expected 1 seen timeout");
        end
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask : wb

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [31:0] r);
        wb(1'b0, a, 32'h0, r);
    endtask : rd

    task automatic settle;
        @(posedge clk_i);
        #1;
    endtask : settle

    task automatic wait_pin(input int b, input logic lvl);
        int n;
        n = 0;
        while (pin_o[b] !== lvl && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
        chk("pin_o wave", 32'(lvl), 32'(pin_o[b]));
    endtask : wait_pin

    // ==========================================================
    // Tests
    logic [2:0]  tc [4] = '{3'h0, 3'h1, 3'h4, 3'h2};
    logic [31:0] lo [4] = '{32'd40, 32'd5, 32'd5, 32'd40};
    logic [31:0] hi [4] = '{32'd400, 32'd11, 32'd31, 32'd400};
    logic [3:0]  wc [3] = '{4'h5, 4'hD, 4'h1};
    logic        dl [3] = '{1'b1, 1'b0, 1'b0};

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(wps_pkg::OFS_ENABLE, q);
        chk("enable", 32'h0, q);
        wr(wps_pkg::OFS_PDIR, 32'h0D);
        wr(wps_pkg::OFS_PDATA, 32'hA5);
        wr(wps_pkg::OFS_FSEL, 32'hFF);
        pin_i <= 8'h3C;
        repeat (4) settle;
        chk("pin_oe_o", 32'h0D, 32'(pin_oe_o));
        chk("pin_o", 32'hA5, 32'(pin_o));
        chk("capture_o", 32'h00, 32'(capture_o));
        wr(wps_pkg::OFS_ENABLE, 32'hFF);
        repeat (4) settle;
        chk("pin_oe_o", 32'h0D, 32'(pin_oe_o));
        chk("pin_o", 32'hA5, 32'(pin_o));
        chk("capture_o", 32'h3C, 32'(capture_o));
        rd(wps_pkg::OFS_PINS, q);
        chk("pins", 32'h3C, q);
        wr(wps_pkg::OFS_FSEL, 32'h00);
        foreach (tc[i]) begin
            wr(wps_pkg::OFS_WAVE, (i % 2 == 0) ? 32'(wps_pkg::MODE_SINGLE) :
                                                 32'(wps_pkg::MODE_PHASE));
            settle;
            chk("pin_oe_o", 32'hFF, 32'(pin_oe_o));
            chk("pin_o", 32'h5A, 32'(pin_o));
        end
        // No tick has run yet, so the even pin shows its default level, inverted when the invert bit is set.
        foreach (wc[i]) begin
            wr(wps_pkg::OFS_WAVE, 32'(wc[i]));
            settle;
            chk("pin_o even", 32'(dl[i]), 32'(pin_o[0]));
        end
        chk("pin_oe_o", 32'hFD, 32'(pin_oe_o));
        chk("pin_o", 32'h58, 32'(pin_o));
        wr(wps_pkg::OFS_CMP, 32'd20);
        wr(wps_pkg::OFS_CMP + 6'h04, 32'd60);
        @(posedge clk_i);
        tick_i <= 1'b1;
        wait_pin(0, 1'b1);
        rd(wps_pkg::OFS_TIMER, q);
        chk_in("timer at set", 32'd20, 32'd28, q);
        rd(wps_pkg::OFS_STATUS, q);
        chk("status", 32'h1, q);
        wait_pin(0, 1'b0);
        tick_i <= 1'b0;
        rd(wps_pkg::OFS_STATUS, q);
        chk("status", 32'h3, q);
        wr(wps_pkg::OFS_IRQEN, 32'h0);
        settle;
        chk("irq_o", 32'h0, 32'(irq_o));
        wr(wps_pkg::OFS_IRQEN, 32'h2);
        settle;
        chk("irq_o", 32'h1, 32'(irq_o));
        wr(wps_pkg::OFS_CLEAR, 32'h2);
        rd(wps_pkg::OFS_STATUS, q);
        chk("status", 32'h1, q);
        chk("irq_o", 32'h0, 32'(irq_o));
        wr(wps_pkg::OFS_IRQEN, 32'h3);
        settle;
        chk("irq_o", 32'h1, 32'(irq_o));
        wr(wps_pkg::OFS_CLEAR, 32'h3);
        rd(wps_pkg::OFS_STATUS, q);
        chk("status", 32'h0, q);
        rd(6'h3E, q);
        wr(wps_pkg::OFS_ENABLE, 32'hFC);
        settle;
        chk("pin_oe_o", 32'hFD, 32'(pin_oe_o));
        chk("pin_o", 32'h59, 32'(pin_o));
        // Each case starts from reset so the timer begins at zero.
        foreach (tc[i]) begin
            @(posedge clk_i);
            rst_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            rst_i <= 1'b0;
            wr(wps_pkg::OFS_CMP, 32'd10);
            wr(wps_pkg::OFS_PERIOD, 32'd30);
            wr(wps_pkg::OFS_TCTRL, 32'(tc[i]));
            wr(wps_pkg::OFS_WAVE, 32'(wps_pkg::MODE_SR));
            wr(wps_pkg::OFS_ENABLE, 32'h03);
            @(posedge clk_i);
            tick_i <= 1'b1;
            mx = 32'h0;
            repeat (40) begin
                rd(wps_pkg::OFS_TIMER, q);
                if (q > mx) mx = q;
            end
            tick_i <= 1'b0;
            chk_in("timer max", lo[i], hi[i], mx);
            if (tc[i] == 3'h1) chk("pair held", 32'h0, 32'(pin_o[0]));
        end
        test_done;
    end

    initial begin
        #300000;
        errors++;
        test_done;
    end
endmodule : waveform_pin_select_tb_top
